// ===== common/cppt_regs.vh
// Constants for the cable plug power and thermal policy block.
// Included by the objects and policy design files and the bench; holds definitions only.
`ifndef CPPT_REGS_VH
`define CPPT_REGS_VH

// Register byte offsets
`define CPPT_OFF_CTRL 8'h00
`define CPPT_OFF_STATUS 8'h04
`define CPPT_OFF_SRC_CAP 8'h08
`define CPPT_OFF_CURRENT 8'h0c
`define CPPT_OFF_TEMP 8'h10
`define CPPT_OFF_REQ 8'h14
`define CPPT_OFF_SNKCAP 8'h18
`define CPPT_OFF_ID_TEMP 8'h1c

// Control register bits
`define CPPT_CTRL_ACTIVE 0
`define CPPT_CTRL_VBUS 1
`define CPPT_CTRL_HRST 2
`define CPPT_CTRL_DISC 3
`define CPPT_CTRL_METAL 4
`define CPPT_CTRL_UNCHK 5
`define CPPT_CTRL_SRCV 6
`define CPPT_CTRL_POS_LO 8
`define CPPT_CTRL_POS_HI 10

// Request object layout
`define CPPT_RDO_POS_INIT 3'h1
`define CPPT_RDO_POS_LSB 28
`define CPPT_RDO_GIVEBACK 27
`define CPPT_RDO_MISMATCH 26
`define CPPT_RDO_COMM 25
`define CPPT_RDO_NOSUSP 24
`define CPPT_RDO_UNCHK 23
`define CPPT_RDO_OPC_LSB 10
`define CPPT_RDO_MAX_LSB 0

// Sink capability object layout
`define CPPT_PDO_FIXED 2'h0
`define CPPT_PDO_TYPE_LSB 30
`define CPPT_PDO_CUR_LSB 0
`define CPPT_PDO_COMM 26
`define CPPT_PDO_DRD 25
`define CPPT_PDO_VOLT 10'h064
`define CPPT_PDO_VOLT_LSB 10
`define CPPT_SRC_DRD_BIT 25

// Current register fields, 10 bits each
`define CPPT_CUR_MAX_LSB 0
`define CPPT_CUR_OPC_LSB 10
`define CPPT_CUR_SNK_LSB 20

// Skin limits and default reported maximum temperature in degrees Celsius
`define CPPT_TEMP_PLASTIC 8'h50
`define CPPT_TEMP_METAL 8'h37
`define CPPT_TEMP_MAX_DEF 8'h4b

// Timing: clock in kHz, wait and refresh times in ms
`define CPPT_CLK_KHZ 20000
`define CPPT_SINK_WAIT_MS 500
`define CPPT_REFRESH_MS 500

`endif

// ===== verilog/cppt_timer.v
// Down-counter that pulses once when a started interval runs out.
// Assumes one clock; start restarts it, stop abandons it.
`timescale 1ns/100ps
module cppt_timer #(
  parameter [31:0] CYCLES = 32'h0000_0010
) (
  input wire aclk,
  input wire aresetn,
  input wire start,
  input wire stop,
  output reg expired
);
  reg [31:0] cnt_q;
  reg run_q;

  // Count down while running, pulse at zero
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 32'h0;
      run_q <= 1'b0;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (start) begin
        cnt_q <= CYCLES - 32'h1;
        run_q <= 1'b1;
      end else if (stop) begin
        run_q <= 1'b0;
      end else if (run_q) begin
        if (cnt_q == 32'h0) begin
          run_q <= 1'b0;
          expired <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 32'h1;
        end
      end
    end
  end
endmodule

// ===== verilog/cppt_objects.v
// Builds the request and sink capability words for the two contracts.
// Assumes all inputs are register outputs of the same clock domain.
`timescale 1ns/100ps
`include "cppt_regs.vh"
module cppt_objects (
  input wire aclk,
  input wire aresetn,
  input wire active,
  input wire [2:0] obj_pos,
  input wire unchk_remote,
  input wire drd_remote,
  input wire [9:0] op_current,
  input wire [9:0] max_current,
  input wire [9:0] snk_current,
  output reg [31:0] request_q,
  output reg [31:0] sink_cap_q
);
  reg [31:0] request_d;
  reg [31:0] sink_cap_d;

  // Assemble both objects; reserved bits left zero
  always @* begin
    request_d = 32'h0;
    request_d[`CPPT_RDO_GIVEBACK] = 1'b0; // see RULE3
    request_d[`CPPT_RDO_MISMATCH] = 1'b0; // see RULE3
    request_d[`CPPT_RDO_COMM] = 1'b1; // see RULE3
    request_d[`CPPT_RDO_NOSUSP] = 1'b1; // see RULE3
    if (active) begin
      request_d[`CPPT_RDO_POS_LSB +: 3] = obj_pos; // see RULE5
      request_d[`CPPT_RDO_UNCHK] = unchk_remote; // see RULE5
      request_d[`CPPT_RDO_OPC_LSB +: 10] = op_current;
      request_d[`CPPT_RDO_MAX_LSB +: 10] = max_current;
    end else begin
      request_d[`CPPT_RDO_POS_LSB +: 3] = `CPPT_RDO_POS_INIT; // see RULE3
      request_d[`CPPT_RDO_UNCHK] = 1'b0; // see RULE3
      request_d[`CPPT_RDO_OPC_LSB +: 10] = 10'h0; // see RULE4
      request_d[`CPPT_RDO_MAX_LSB +: 10] = 10'h0; // see RULE4
    end
    sink_cap_d = 32'h0; // see RULE7
    sink_cap_d[`CPPT_PDO_TYPE_LSB +: 2] = `CPPT_PDO_FIXED; // see RULE6
    sink_cap_d[`CPPT_PDO_COMM] = 1'b1; // see RULE7
    sink_cap_d[`CPPT_PDO_DRD] = drd_remote; // see RULE8
    sink_cap_d[`CPPT_PDO_VOLT_LSB +: 10] = `CPPT_PDO_VOLT; // see RULE6
    sink_cap_d[`CPPT_PDO_CUR_LSB +: 10] = snk_current; // see RULE6
  end

  // Register the objects
  always @(posedge aclk) begin
    if (!aresetn) begin
      request_q <= 32'h0;
      sink_cap_q <= 32'h0;
    end else begin
      request_q <= request_d; // see RULE1
      sink_cap_q <= sink_cap_d;
    end
  end
endmodule

// ===== verilog/cppt_policy.v
// Power contract and thermal policy logic of an optically isolated cable plug.
// Assumes an AXI4-Lite master on aclk and a sensor that gives temperature in Celsius.
// Summary of operation
// RULE1: Hold an initial contract and a second contract once Active.
// RULE2: After bus supply appears, wait sink_cap_wait_time then issue Hard Reset.
// RULE3: Initial request: position 1, comm and no-suspend set, other flags clear.
// RULE4: Initial request carries zero operating and maximum current.
// RULE5: Active request uses chosen position and remote unchunked bit; currents by software.
// RULE6: Active sink capability: fixed supply, 5 V, software current.
// RULE7: Active sink capability clears power flags, sets comm, no fast swap.
// RULE8: Dual-role-data bit mirrors far side capability.
// RULE9: Learn local dual-role-data from bit 25 of source capabilities.
// RULE10: Before Active, only restricted initialization messages are allowed.
// RULE11: Work with the minimum source offer; higher requests optional.
// RULE12: At skin limit force superspeed into the disabled state.
// RULE13: Report shutdown in the status answer.
// RULE14: Present a Billboard error while in shutdown.
// RULE15: Shutdown stays latched until disconnect or Hard Reset.
// RULE16: Report maximum internal temperature for identity answers.
// RULE17: Report current internal temperature for status answers.
// RULE18: Refresh reported temperature at least every 500 ms.
// RULE19: Reported temperature is in Celsius and monotonic.
// RULE20: Far side polls temperature about every two seconds.
// RULE21: One shutdown flag drives disable, Billboard and status together.
//
// Our own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps
`include "cppt_regs.vh"
module cppt_policy #(
  parameter [31:0] SINK_WAIT_CYCLES = `CPPT_SINK_WAIT_MS * `CPPT_CLK_KHZ,
  parameter [31:0] REFRESH_CYCLES = `CPPT_REFRESH_MS * `CPPT_CLK_KHZ
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] awaddr,
  input wire [2:0] awprot,
  input wire awvalid,
  output wire awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output wire wready,
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  input wire [7:0] araddr,
  input wire [2:0] arprot,
  input wire arvalid,
  output wire arready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  input wire [7:0] sensor_temp,
  output reg superspeed_disabled_state,
  output reg billboard_error,
  output reg hard_reset_req
);
  localparam ST_INIT = 3'b001;
  localparam ST_WAIT = 3'b010;
  localparam ST_ACTIVE = 3'b100;

  // Software-visible state
  reg [31:0] ctrl_q;
  reg [31:0] src_cap_q;
  reg [31:0] current_q;
  reg [7:0] max_temp_q;
  reg [7:0] temp_q;
  reg shutdown_q;
  reg refresh_run_q;
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg vbus_q;
  reg local_drd_q;
  reg aw_held_q;
  reg w_held_q;
  reg [7:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  wire [31:0] request_q;
  wire [31:0] sink_cap_q;
  wire wait_done;
  wire refresh_tick;
  wire do_write;
  wire hrst_evt;
  wire disc_evt;
  wire vbus_rise;
  wire active;
  wire [7:0] limit;
  wire [31:0] wmask;
  wire [31:0] status_w;
  reg [31:0] rd_d;
  reg rd_ok;

  assign active = ctrl_q[`CPPT_CTRL_ACTIVE];
  assign vbus_rise = ctrl_q[`CPPT_CTRL_VBUS] & ~vbus_q;
  assign do_write = aw_held_q & w_held_q & ~bvalid;
  assign wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  assign hrst_evt = do_write & (aw_addr_q == `CPPT_OFF_CTRL) & w_strb_q[0] & w_data_q[`CPPT_CTRL_HRST];
  assign disc_evt = do_write & (aw_addr_q == `CPPT_OFF_CTRL) & w_strb_q[0] & w_data_q[`CPPT_CTRL_DISC];
  // Housing selects the skin limit
  assign limit = ctrl_q[`CPPT_CTRL_METAL] ? `CPPT_TEMP_METAL : `CPPT_TEMP_PLASTIC; // see RULE12

  // Accept address and data independently, one write at a time
  assign awready = ~aw_held_q & ~bvalid;
  assign wready = ~w_held_q & ~bvalid;
  assign arready = ~rvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= 8'h0;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
    end else begin
      if (awvalid && awready) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_held_q <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (do_write) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        bvalid <= 1'b1;
        bresp <= (aw_addr_q == `CPPT_OFF_CTRL || aw_addr_q == `CPPT_OFF_SRC_CAP ||
                  aw_addr_q == `CPPT_OFF_CURRENT || aw_addr_q == `CPPT_OFF_ID_TEMP) ? 2'h0 : 2'h2;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Writable registers; pulse bits self-clear
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= 32'h0;
      src_cap_q <= 32'h0;
      current_q <= 32'h0;
      max_temp_q <= `CPPT_TEMP_MAX_DEF;
      vbus_q <= 1'b0;
      local_drd_q <= 1'b0;
    end else begin
      vbus_q <= ctrl_q[`CPPT_CTRL_VBUS];
      ctrl_q[`CPPT_CTRL_HRST] <= 1'b0;
      ctrl_q[`CPPT_CTRL_DISC] <= 1'b0;
      ctrl_q[`CPPT_CTRL_SRCV] <= 1'b0;
      if (do_write) begin
        case (aw_addr_q)
          `CPPT_OFF_CTRL: begin
            ctrl_q <= (ctrl_q & ~wmask) | (w_data_q & wmask);
          end
          `CPPT_OFF_SRC_CAP: begin
            src_cap_q <= (src_cap_q & ~wmask) | (w_data_q & wmask);
            local_drd_q <= w_strb_q[3] ? w_data_q[`CPPT_SRC_DRD_BIT] : local_drd_q; // see RULE9
          end
          `CPPT_OFF_CURRENT: begin
            current_q <= (current_q & ~wmask) | (w_data_q & wmask);
          end
          `CPPT_OFF_ID_TEMP: begin
            max_temp_q <= w_strb_q[0] ? w_data_q[7:0] : max_temp_q; // see RULE16
          end
          default: begin
            ctrl_q <= ctrl_q;
          end
        endcase
      end
      // Disconnect or Hard Reset drops the Active contract
      if (hrst_evt || disc_evt) begin
        ctrl_q[`CPPT_CTRL_ACTIVE] <= 1'b0;
      end
    end
  end

  // Contract phase machine
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_INIT: begin
        if (vbus_rise) begin
          state_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (wait_done || hrst_evt || disc_evt) begin
          state_d = active ? ST_ACTIVE : ST_INIT;
        end
      end
      ST_ACTIVE: begin
        if (vbus_rise) begin
          state_d = ST_WAIT;
        end else if (!active) begin
          state_d = ST_INIT;
        end
      end
      default: begin
        state_d = ST_INIT;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_INIT;
      hard_reset_req <= 1'b0;
    end else begin
      state_q <= state_d;
      hard_reset_req <= (state_q == ST_WAIT) & wait_done; // see RULE2
    end
  end

  // Sink capability wait after supply arrives, in either phase
  cppt_timer #(
    .CYCLES(SINK_WAIT_CYCLES)
  ) u_wait (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(vbus_rise), // see RULE2
    .stop(hrst_evt | disc_evt),
    .expired(wait_done)
  );

  // Periodic temperature refresh tick, first started right after reset
  // Restart costs one cycle per period, so load one less than the interval
  cppt_timer #(
    .CYCLES(REFRESH_CYCLES - 32'h1)
  ) u_refresh (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(refresh_tick | ~refresh_run_q), // see RULE18
    .stop(1'b0),
    .expired(refresh_tick)
  );

  // Sampled temperature and latched shutdown flag
  always @(posedge aclk) begin
    if (!aresetn) begin
      temp_q <= 8'h0;
      shutdown_q <= 1'b0;
      refresh_run_q <= 1'b0;
      superspeed_disabled_state <= 1'b1;
      billboard_error <= 1'b0;
    end else begin
      refresh_run_q <= 1'b1;
      if (refresh_tick) begin
        temp_q <= sensor_temp; // see RULE18
      end
      if (sensor_temp >= limit) begin
        shutdown_q <= 1'b1; // see RULE21
      end else if (hrst_evt || disc_evt) begin
        shutdown_q <= 1'b0; // see RULE15
      end
      superspeed_disabled_state <= shutdown_q | ~active; // see RULE12
      billboard_error <= shutdown_q; // see RULE14
    end
  end

  // Request and capability objects
  cppt_objects u_obj (
    .aclk(aclk),
    .aresetn(aresetn),
    .active(active), // see RULE1
    .obj_pos(ctrl_q[`CPPT_CTRL_POS_HI:`CPPT_CTRL_POS_LO]), // see RULE11
    .unchk_remote(ctrl_q[`CPPT_CTRL_UNCHK]),
    .drd_remote(local_drd_q),
    .op_current(current_q[`CPPT_CUR_OPC_LSB +: 10]),
    .max_current(current_q[`CPPT_CUR_MAX_LSB +: 10]),
    .snk_current(current_q[`CPPT_CUR_SNK_LSB +: 10]),
    .request_q(request_q),
    .sink_cap_q(sink_cap_q)
  );

  // Status: shutdown, phase and restricted message mode
  assign status_w = {23'h0, ~active, state_q, local_drd_q, vbus_q, 2'h0, shutdown_q}; // see RULE13, RULE10

  // Read mux
  always @* begin
    rd_d = 32'h0;
    rd_ok = 1'b1;
    case (araddr)
      `CPPT_OFF_CTRL: rd_d = ctrl_q;
      `CPPT_OFF_STATUS: rd_d = status_w;
      `CPPT_OFF_SRC_CAP: rd_d = src_cap_q;
      `CPPT_OFF_CURRENT: rd_d = current_q;
      `CPPT_OFF_TEMP: rd_d = {24'h0, temp_q}; // see RULE17, RULE19
      `CPPT_OFF_REQ: rd_d = request_q;
      `CPPT_OFF_SNKCAP: rd_d = sink_cap_q;
      `CPPT_OFF_ID_TEMP: rd_d = {24'h0, max_temp_q}; // see RULE16
      default: rd_ok = 1'b0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= 2'h0;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= rd_d;
      rresp <= rd_ok ? 2'h0 : 2'h2;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule

// ===== tb/cppt_policy_sva.sv
// Port checker for the policy block.
// Assumes one clock domain and a bind onto cppt_policy.
`timescale 1ns/100ps
module cppt_policy_chk #(
  parameter [31:0] SINK_WAIT_CYCLES = 32'h0000_0010,
  parameter [31:0] REFRESH_CYCLES = 32'h0000_0010
) (
  input wire aclk,
  input wire aresetn,
  input wire awvalid,
  input wire arready,
  input wire [1:0] bresp,
  input wire bvalid,
  input wire bready,
  input wire [31:0] rdata,
  input wire rvalid,
  input wire rready,
  input wire [7:0] sensor_temp,
  input wire superspeed_disabled_state,
  input wire billboard_error,
  input wire hard_reset_req
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Responses stand until taken
  AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  AST_AR_BLOCK: assert property (rvalid |-> !arready)
    else $error("read taken while busy");
  // Thermal shutdown behaviour and Hard Reset pulse
  AST_SHUT_SET: assert property (sensor_temp >= 8'h50 |-> ##[1:3] (billboard_error && superspeed_disabled_state))
    else $error("no shutdown at limit");
  AST_BB_SS: assert property (billboard_error |-> superspeed_disabled_state)
    else $error("billboard without disable");
  AST_BB_RISE: assert property ($rose(billboard_error) |-> $past(sensor_temp, 2) >= 8'h37)
    else $error("shutdown below limit");
  AST_BB_STICKY: assert property ((billboard_error && !awvalid) [*6] |=> billboard_error)
    else $error("shutdown cleared alone");
  AST_HR_PULSE: assert property (hard_reset_req |=> !hard_reset_req)
    else $error("hard reset not a pulse");
  // Main scenarios reached
  cover property ($rose(hard_reset_req));
  cover property ($rose(billboard_error));
  cover property (bvalid && bresp == 2'h2);
endmodule

bind cppt_policy cppt_policy_chk #(.SINK_WAIT_CYCLES(SINK_WAIT_CYCLES), .REFRESH_CYCLES(REFRESH_CYCLES)) u_chk (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .arready(arready), .bresp(bresp), .bvalid(bvalid),
  .bready(bready), .rdata(rdata), .rvalid(rvalid), .rready(rready), .sensor_temp(sensor_temp),
  .superspeed_disabled_state(superspeed_disabled_state), .billboard_error(billboard_error),
  .hard_reset_req(hard_reset_req));

// ===== tb/cppt_sensor_model.sv
// Temperature sensor of the plug, as the policy block sees it.
// Assumes the bench sets a target; the reading walks one degree a cycle.
`timescale 1ns/100ps
module cppt_sensor_model (
  input wire aclk,
  input wire [7:0] target,
  output reg [7:0] sensor_temp
);
  initial sensor_temp = 8'h19;
  // Monotonic walk in whole degrees Celsius
  always @(posedge aclk) begin
    if (sensor_temp < target) sensor_temp <= sensor_temp + 8'h01;
    else if (sensor_temp > target) sensor_temp <= sensor_temp - 8'h01;
  end
endmodule

// ===== tb/tb_cable_plug_power_thermal_policy.sv
// Self-checking bench for the plug power and thermal policy block.
// Assumes the design, checker and sensor model are compiled first.
`timescale 1ns/100ps
`include "cppt_regs.vh"
module tb_cable_plug_power_thermal_policy;
  reg aclk = 1'b0;
  reg aresetn = 1'b0;
  reg [7:0] awaddr = 8'h00, araddr = 8'h00, target = 8'h19, lim;
  reg [31:0] wdata = 32'h0, rd_q;
  reg [3:0] wstrb = 4'hf;
  reg [2:0] prot = 3'h0;
  reg [1:0] rsp;
  reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  wire awready, wready, bvalid, arready, rvalid, ss_off, bb_err, hr_req;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [7:0] sensor_temp;
  integer err_total = 0, total_checks = 0, cyc = 0, n, k;
  always #25 aclk = ~aclk;
  cppt_sensor_model u_sens (.aclk(aclk), .target(target), .sensor_temp(sensor_temp));
  cppt_policy #(.SINK_WAIT_CYCLES(32'h10), .REFRESH_CYCLES(32'h10)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(prot), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arprot(prot), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .sensor_temp(sensor_temp),
    .superspeed_disabled_state(ss_off), .billboard_error(bb_err), .hard_reset_req(hr_req));
  task final_report;
    begin
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  // Cycle ceiling against hangs
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      err_total = err_total + 1;
      final_report;
    end
  end
  task chk(input [8*10-1:0] nm, input [31:0] exp, input [31:0] got);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("MISMATCH %0s exp %h got %h", nm, exp, got);
      end
    end
  endtask
  task wt(input integer c);
    repeat (c) @(posedge aclk);
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
        @(posedge aclk);
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      rsp = bresp;
      bready <= 1'b0;
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
        @(posedge aclk);
        if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rd_q = rdata;
      rsp = rresp;
      rready <= 1'b0;
    end
  endtask
  // Counts cycles to a hard reset pulse, 40 if none
  task wait_hr;
    for (k = 0; k < 40 && !hr_req; k = k + 1) @(posedge aclk);
  endtask
  task t_init;
    begin
      chk("ss_off", 1, ss_off);
      rd(`CPPT_OFF_REQ);
      chk("req_init", 32'h1300_0000, rd_q);
      rd(`CPPT_OFF_ID_TEMP);
      chk("id_temp", 32'h4b, rd_q);
      wr(`CPPT_OFF_ID_TEMP, 32'h5a);
      rd(`CPPT_OFF_ID_TEMP);
      chk("id_temp", 32'h5a, rd_q);
      rd(8'h20);
      chk("rd_resp", 2'h2, rsp);
      wr(`CPPT_OFF_REQ, 32'h0);
      chk("wr_resp", 2'h2, rsp);
      rd(`CPPT_OFF_STATUS);
      chk("restrict", 1, rd_q[8]);
      $display("test init done");
    end
  endtask
  task t_active;
    begin
      wr(`CPPT_OFF_CURRENT, 32'h0961_9032);
      for (n = 0; n < 2; n = n + 1) begin
        wr(`CPPT_OFF_SRC_CAP, n << 25);
        wr(`CPPT_OFF_CTRL, 32'h201 | (n << 5));
        wt(3);
        rd(`CPPT_OFF_REQ);
        chk("req_act", 32'h2301_9032 | (n << 23), rd_q);
        rd(`CPPT_OFF_SNKCAP);
        chk("snk_cap", 32'h0401_9096 | (n << 25), rd_q);
        rd(`CPPT_OFF_STATUS);
        chk("restrict", 0, rd_q[8]);
        chk("ss_off", 0, ss_off);
      end
      $display("test active done");
    end
  endtask
  task t_thermal;
    for (n = 0; n < 2; n = n + 1) begin
      lim = n ? 8'h37 : 8'h50;
      wr(`CPPT_OFF_CTRL, 32'h201 | (n << 4));
      target <= lim - 8'h01;
      wt(120);
      chk("bb_low", 0, bb_err);
      target <= lim;
      wt(6);
      chk("bb_set", 1, bb_err);
      chk("ss_set", 1, ss_off);
      rd(`CPPT_OFF_STATUS);
      chk("st_shut", 1, rd_q[0]);
      target <= 8'h19;
      wt(120);
      chk("bb_latch", 1, bb_err);
      rd(`CPPT_OFF_TEMP);
      chk("temp", 32'h19, rd_q);
      wr(`CPPT_OFF_CTRL, (n << 4) | (n ? 32'h8 : 32'h4));
      wt(4);
      chk("bb_clr", 0, bb_err);
      $display("test thermal %0d done", n);
    end
  endtask
  task t_hreset;
    begin
      for (n = 0; n < 2; n = n + 1) begin
        wr(`CPPT_OFF_CTRL, 32'h0);
        wr(`CPPT_OFF_CTRL, 32'h2 | n);
        wait_hr;
        chk("hr_gap", 1, k >= 14 && k <= 20);
      end
      wr(`CPPT_OFF_CTRL, 32'h0);
      wr(`CPPT_OFF_CTRL, 32'h2);
      wr(`CPPT_OFF_CTRL, 32'h4);
      wait_hr;
      chk("hr_abort", 40, k);
      $display("test hard reset done");
    end
  endtask
  // Main sequence
  initial begin
    wt(6);
    aresetn <= 1'b1;
    t_init;
    t_active;
    t_thermal;
    t_hreset;
    final_report;
  end
endmodule
